// [hw/rsi_pkg.sv]
// Purpose: Shared constants for the reset initial-state block
// Assumes: 8-bit data path, one clock
// Notes: Default values loaded per reset cause
package rsi_pkg;
    localparam int RSI_DW = 8;
    localparam logic [7:0] RSI_PORT_DATA_RST = 8'hff;
    localparam logic [7:0] RSI_PORT_DIR_RST = 8'hff;
    localparam logic [7:0] RSI_PULLUP_RST = 8'h00;
    localparam logic [7:0] RSI_PC_LOW_RST = 8'h00;
    localparam logic [7:0] RSI_INTEN_RST = 8'h00;
    localparam logic [7:0] RSI_TMRCTL_RST = 8'h08;
    localparam int RSI_TMR_ON_BIT = 4;
    localparam logic [6:0] RSI_PRESC_RST = 7'h00;
    localparam logic [5:0] RSI_DOG_RST = 6'h00;
    localparam logic [1:0] RSI_SP_TOP = 2'h0;
endpackage

// [hw/rsi_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous reset requests
// Assumes: Input comes from outside the clock domain
// Notes: Stage one feeds stage two only
`timescale 1ns/1ps
`default_nettype none
module rsi_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_ff <= '0;
            q <= '0;
        end else begin
            s1_ff <= d;
            q <= s1_ff;
        end
    end
endmodule
`default_nettype wire

// [hw/rsi_top.sv]
// Purpose: Reset cause resolution and initial state of core registers
// Assumes: rst is the power-on reset; pin and low-voltage requests are async levels
// Notes: Watchdog time-out and sleep state come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Power-on reset clears both the power-down flag and the time-out flag.
// - A pin or low-voltage reset while running leaves both flags unchanged.
// - A watchdog time-out while running sets the time-out flag and keeps the power-down flag.
// - A watchdog time-out while idle or asleep sets both flags.
// - Every reset disables all interrupt sources.
// - Every reset clears the watchdog counter, which then counts at once.
// - Every reset switches the timer/event counter off.
// - Every reset clears the timer prescaler.
// - A non-sleep reset sets port data and direction to all ones and clears pull-ups.
// - Every reset points the stack pointer at the top of the return stack.
// - All causes but a sleep watchdog load the same defaults; that one keeps ports and timer control bar its on bit; all clear the PC low byte.
module rsi_top
    import rsi_pkg::*;
#(
    parameter int NPORT = 4,
    parameter int SP_W = 2
) (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // Reset requests
    input wire logic external_reset_pin_n,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    // Software flag set and clear (e.g. sleep entry sets power-down, clear-watchdog clears both)
    input wire logic sw_set_power_down,
    input wire logic sw_clr_flags,
    // Watchdog tick enable
    input wire logic watchdog_tick,
    // Status flags
    output logic power_down_flag,
    output logic timeout_flag,
    // Core state
    output logic core_reset,
    output logic [rsi_pkg::RSI_DW-1:0] program_counter_low,
    output logic [SP_W-1:0] stack_ptr,
    output logic [rsi_pkg::RSI_DW-1:0] int_enable,
    output logic [rsi_pkg::RSI_DW-1:0] timer_ctrl,
    output logic [6:0] prescaler,
    output logic [5:0] watchdog_counter,
    output logic [NPORT*rsi_pkg::RSI_DW-1:0] port_data,
    output logic [NPORT*rsi_pkg::RSI_DW-1:0] port_dir,
    output logic [NPORT*rsi_pkg::RSI_DW-1:0] port_pullup
);
    import rsi_pkg::*;

    logic [1:0] async_req;
    logic pin_req;
    logic lowv_req;
    logic pin_rst;
    logic dog_run;
    logic dog_idle;
    logic any_rst;
    logic full_rst;
    logic nxt_power_down;
    logic nxt_to;
    logic tmr_on;

    rsi_sync #(.W(2)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d({~external_reset_pin_n, low_voltage_reset}),
        .q(async_req)
    );

    assign pin_req = async_req[1];
    assign lowv_req = async_req[0];
    assign pin_rst = pin_req | lowv_req;
    // Pin or supply reset outranks a simultaneous watchdog time-out
    assign dog_run = watchdog_timeout & ~sleep_mode & ~pin_rst;
    assign dog_idle = watchdog_timeout & sleep_mode & ~pin_rst;
    assign any_rst = rst | pin_rst | watchdog_timeout;
    // Causes that restore full defaults (all but sleep watchdog)
    assign full_rst = rst | pin_rst | dog_run;
    assign tmr_on = timer_ctrl[RSI_TMR_ON_BIT];

    // Flag update: hardware set wins over software clear
    always_comb begin
        nxt_power_down = power_down_flag;
        nxt_to = timeout_flag;
        if (sw_clr_flags) begin
            nxt_power_down = 1'b0;
            nxt_to = 1'b0;
        end
        if (sw_set_power_down) begin
            nxt_power_down = 1'b1;
        end
        if (pin_rst) begin
            nxt_power_down = power_down_flag;
            nxt_to = timeout_flag;
        end else if (dog_idle) begin
            nxt_power_down = 1'b1;
            nxt_to = 1'b1;
        end else if (dog_run) begin
            nxt_to = 1'b1;
            nxt_power_down = power_down_flag;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            power_down_flag <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            power_down_flag <= nxt_power_down;
            timeout_flag <= nxt_to;
        end
    end

    // Core reset strobe, high the cycle after any cause
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= pin_rst | watchdog_timeout;
        end
    end

    // Program counter and stack pointer, cleared by every cause
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            program_counter_low <= RSI_PC_LOW_RST;
            stack_ptr <= SP_W'(RSI_SP_TOP);
        end
    end

    // Interrupt enables clear and timer control keeps all but its on bit on sleep watchdog reset
    always_ff @(posedge mclk) begin
        if (full_rst) begin
            int_enable <= RSI_INTEN_RST;
            timer_ctrl <= RSI_TMRCTL_RST;
        end else if (dog_idle) begin
            int_enable <= RSI_INTEN_RST;
            timer_ctrl[RSI_TMR_ON_BIT] <= 1'b0;
        end
    end

    // Prescaler runs while the timer is on
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            prescaler <= RSI_PRESC_RST;
        end else if (tmr_on) begin
            prescaler <= prescaler + 7'h01;
        end
    end

    // Watchdog clears on reset then counts without software help
    always_ff @(posedge mclk) begin
        if (any_rst || sw_clr_flags) begin
            watchdog_counter <= RSI_DOG_RST;
        end else if (watchdog_tick) begin
            watchdog_counter <= watchdog_counter + 6'h01;
        end
    end

    // Per-port I/O defaults
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            always_ff @(posedge mclk) begin
                if (full_rst) begin
                    port_data[gi*RSI_DW +: RSI_DW] <= RSI_PORT_DATA_RST;
                    port_dir[gi*RSI_DW +: RSI_DW] <= RSI_PORT_DIR_RST;
                    port_pullup[gi*RSI_DW +: RSI_DW] <= RSI_PULLUP_RST;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [test/rsi_top_asserts.sv]
// Purpose: Port assertions for rsi_top
// Assumes: One clock, sync reset
// Notes: ok_ff marks a quiet pin and supply
`timescale 1ns/1ps
`default_nettype none
module rsi_chk
    import rsi_pkg::*;
#(parameter int NPORT = 4) (
    // Clock, reset and requests
    input wire logic mclk,
    input wire logic rst,
    input wire logic external_reset_pin_n,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    input wire logic watchdog_tick,
    // Watched outputs
    input wire logic power_down_flag,
    input wire logic timeout_flag,
    input wire logic core_reset,
    input wire logic [5:0] watchdog_counter,
    input wire logic [NPORT*8-1:0] port_dir
);
    logic [3:0] ok_ff;
    logic hw;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) ok_ff <= {ok_ff[2:0], external_reset_pin_n & ~low_voltage_reset};
    assign hw = &ok_ff && watchdog_timeout;
    chk_por_flags: assert property ($past(rst) |-> !timeout_flag && !power_down_flag)
        else $error("por flags");
    chk_pin_flags: assert property ((!external_reset_pin_n || low_voltage_reset) [*4] |=>
        $stable({timeout_flag, power_down_flag})) else $error("pin flags");
    chk_run_flags: assert property (hw && !sleep_mode |=> timeout_flag && $stable(power_down_flag))
        else $error("run flags");
    chk_idle_flags: assert property (hw && sleep_mode |=> timeout_flag && power_down_flag)
        else $error("idle flags");
    chk_watchdog_clear: assert property (core_reset |-> watchdog_counter == RSI_DOG_RST)
        else $error("watchdog not clear");
    chk_watchdog_runs: assert property ($fell(core_reset) && !$past(watchdog_tick) && watchdog_tick && &ok_ff
        && !watchdog_timeout |=> watchdog_counter == 6'h01) else $error("watchdog idle");
    chk_port_inputs: assert property (hw && !sleep_mode |=> port_dir == {NPORT{RSI_PORT_DIR_RST}})
        else $error("ports not inputs");
    chk_idle_ports: assert property (hw && sleep_mode |=> $stable(port_dir))
        else $error("idle ports moved");
    cover property (hw && sleep_mode);
    cover property (low_voltage_reset [*4]);
    cover property ($fell(core_reset) && watchdog_tick);
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for rsi_top
// Assumes: Inputs change 10 ns after mclk rises
// Notes: fl holds the expected flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rsi_pkg::*;
    logic mclk = 0, rst = 1, external_reset_pin_n = 1, low_voltage_reset = 0, watchdog_timeout = 0;
    logic sleep_mode = 0, sw_set_power_down = 0, sw_clr_flags = 0, watchdog_tick = 0;
    logic power_down_flag, timeout_flag;
    logic core_reset, cr_d = 0;
    logic [1:0] stack_ptr, fl = 0, exp_q[$];
    logic [7:0] program_counter_low, int_enable, timer_ctrl;
    logic [6:0] prescaler;
    logic [5:0] watchdog_counter;
    logic [31:0] port_data, port_dir, port_pullup;
    int errors = 0, check_count = 0;
    int plan[6] = '{2, 0, 1, 3, 0, 1};
    rsi_top u_rsi_top (.*);
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) #10 watchdog_tick = 1'($urandom);
    task automatic chk(string s, logic [31:0] x, y);
        check_count++;
        if (x !== y) begin
            errors++;
            $display("ERROR %s exp %h got %h", s, x, y);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Cause 0 pin, 1 supply, 2 watchdog running, 3 watchdog asleep
    task automatic req(int k);
        @(posedge mclk) #10;
        {external_reset_pin_n, low_voltage_reset, watchdog_timeout, sleep_mode} = {k != 0, k == 1, k > 1, k == 3};
        if (k > 1) fl = {1'b1, k == 3 || fl[0]};
        exp_q.push_back(fl);
        repeat (4) @(posedge mclk);
        #10 {external_reset_pin_n, low_voltage_reset, watchdog_timeout, sleep_mode} = 4'h8;
        repeat (5) @(posedge mclk);
        #10 chk("release", 0, core_reset);
        if (core_reset) results;
    endtask
    // Looks mid-cycle so the outputs launched at the rising edge have settled
    always @(negedge mclk) begin
        if (!rst && core_reset && !cr_d) begin
            chk("flags", exp_q.pop_front(), {timeout_flag, power_down_flag});
            chk("core", 0, {program_counter_low, stack_ptr, int_enable, watchdog_counter,
                timer_ctrl[RSI_TMR_ON_BIT], prescaler});
            chk("ports", 32'hffffffff, port_data & port_dir & ~port_pullup);
            chk("timer", RSI_TMRCTL_RST, timer_ctrl);
        end
        cr_d <= core_reset;
    end
    initial begin
        void'($urandom(1547));
        repeat (2) @(posedge mclk);
        #10 rst = 0;
        chk("por", 0, {timeout_flag, power_down_flag});
        chk("io", 32'hffffffff, port_data & port_dir & ~port_pullup);
        foreach (plan[i]) req(plan[i]);
        $display("directed done");
        @(posedge mclk) #10 sw_clr_flags = 1;
        @(posedge mclk) #10 sw_clr_flags = 0;
        sw_set_power_down = 1;
        chk("clear", 0, {timeout_flag, power_down_flag});
        @(posedge mclk) #10 sw_set_power_down = 0;
        chk("soft", 2'b01, {timeout_flag, power_down_flag});
        fl = 2'b01;
        req(2);
        $display("software done");
        repeat (30) req($urandom % 4);
        $display("random done");
        results;
    end
endmodule
bind rsi_top rsi_chk #(.NPORT(NPORT)) u_chk (.*);
`default_nettype wire
